/* logic/ccr_control_regs.vh */
/*
 * Register map, field positions, reset values and timing counts for the
 * charger control registers at offsets 0x06 to 0x08.
 * Assumes a 20 MHz system clock and an 8-bit register access port.
 */
`ifndef CCR_CONTROL_REGS_VH
`define CCR_CONTROL_REGS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define CCR_OFS_CONTROL_TWO 8'h06
`define CCR_OFS_CONTROL_THREE 8'h07
`define CCR_OFS_ZONE_LIMITS 8'h08

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CCR_RST_CONTROL_TWO 8'h7D
`define CCR_RST_CONTROL_THREE 8'h00
`define CCR_RST_ZONE_LIMITS 8'h0D

// fixed read value of the read-only low nibble of control three
`define CCR_THREE_RO_VALUE 8'h02

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CCR_TWO_RSVD_BIT 7
`define CCR_TWO_AUTO_DET_BIT 6
`define CCR_TWO_THERM_HI 5
`define CCR_TWO_THERM_LO 4
`define CCR_TWO_CHG_EN_BIT 3
`define CCR_TWO_PRECHG_BIT 2
`define CCR_TWO_RECHG_HI 1
`define CCR_TWO_RECHG_LO 0

`define CCR_THREE_PULSE_OFF_BIT 7
`define CCR_THREE_KICK_BIT 6
`define CCR_THREE_FINISH_HI 5
`define CCR_THREE_FINISH_LO 4

`define CCR_ZONE_HOT_V_HI 4
`define CCR_ZONE_HOT_V_LO 3
`define CCR_ZONE_HOT_I_BIT 2
`define CCR_ZONE_COLD_I_HI 1
`define CCR_ZONE_COLD_I_LO 0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CCR_CLK_HZ 20000000
`define CCR_WD_BASE_S 40
`define CCR_WD_BASE_CYCLES (`CCR_WD_BASE_S * `CCR_CLK_HZ)

`endif

/* logic/ccr_watchdog_timer.v */
/*
 * Host watchdog timer: expires after 1x, 2x or 4x a base period unless kicked.
 * Assumes the period select and the kick come from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module ccr_watchdog_timer #(
	parameter [31:0] P_BASE_CYCLES = 32'd800000000
) (
	// clock and reset
	input wire i_clk_sys,
	input wire i_rst_b,
	input wire i_clk_en,
	// control
	input wire [1:0] i_period_sel,
	input wire i_kick,
	// status
	output reg o_expire_ff
);

	localparam [33:0] L_BASE = {2'b00, P_BASE_CYCLES};

	reg [33:0] cnt_ff;
	reg [33:0] nxt_cnt;
	reg nxt_expire;

	// 00 disables, 01/10/11 select 40 s, 80 s, 160 s
	function [33:0] period_limit;
		input [1:0] sel;
		begin
			case (sel)
				2'b01: period_limit = L_BASE;
				2'b10: period_limit = {L_BASE[32:0], 1'b0};
				2'b11: period_limit = {L_BASE[31:0], 2'b00};
				default: period_limit = 34'h0_0000_0000;
			endcase
		end
	endfunction

	always @* begin
		nxt_cnt = cnt_ff + 34'd1;
		nxt_expire = 1'b0;
		if ((i_period_sel == 2'b00) || i_kick) begin
			nxt_cnt = 34'h0_0000_0000;
		end else if (cnt_ff >= period_limit(i_period_sel) - 34'd1) begin
			// restart after expiry so a silent host sees repeated expiries
			nxt_cnt = 34'h0_0000_0000;
			nxt_expire = 1'b1;
		end
	end

	always @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_ff <= 34'h0_0000_0000;
			o_expire_ff <= 1'b0;
		end else if (i_clk_en) begin
			cnt_ff <= nxt_cnt;
			o_expire_ff <= nxt_expire;
		end
	end

endmodule // ccr_watchdog_timer

`default_nettype wire

/* logic/ccr_control_regs.v */
/*
 * Charger control registers two, three and the temperature zone limits,
 * their decoded settings, the host watchdog and plug-in source detection.
 * Assumes a serial bus slave in front that turns host frames into single
 * cycle read and write strobes on the system clock.
 */
// Function
// - control two at 0x06, defaults to 0x7D on register reset
// - bit 7 of control two always reads zero
// - auto source-detect bit 6 starts detection on input power plug-in
// - thermal threshold bits 5:4 decode 60, 80, 100, 120 degrees C
// - charge enable bit 3; charging wins over reverse boost
// - bit 2 selects precharge exit 2.8 V or 3.0 V per cell
// - recharge offset bits 1:0 weigh 100 and 50 mV, kept on watchdog
// - control three at 0x07, resets to 0x00
// - bit 7 forbids light-load pulse mode; kept on watchdog expiry
// - writing 1 to kick bit restarts watchdog, bit self-clears
// - finish timer bits 5:4 decode off, 15, 30, 45 minutes
// - control three bits 3:0 read only, read as 0010
// - zone limits at 0x08, reset 0x0D, bits 7:5 read zero
// - hot zone bits 4:3 suspend, 8.0 V, 8.3 V or unchanged
// - hot zone bit 2 limits current to 40 or 100 percent
// - cold zone bits 1:0 suspend, 20, 40 or 100 percent
// - watchdog expires after 40/80/160 s and restores its fields
`timescale 1ns/100ps
`default_nettype none
`include "ccr_control_regs.vh"

module ccr_control_regs #(
	parameter [31:0] P_WD_BASE_CYCLES = `CCR_WD_BASE_CYCLES
) (
	// clock, reset, enable
	input wire i_clk_sys,
	input wire i_rst_b,
	input wire i_clk_en,
	// register-defaults reset request, one cycle
	input wire i_reg_reset,
	// register access port
	input wire i_reg_wr,
	input wire i_reg_rd,
	input wire [7:0] i_reg_addr,
	input wire [7:0] i_reg_wdata,
	output reg [7:0] o_reg_rdata_ff,
	// charger context
	input wire i_input_bus_power,
	input wire i_reverse_boost_enable,
	input wire [1:0] i_watchdog_period_sel,
	// watchdog
	output wire o_watchdog_expire,
	output reg o_watchdog_kick_ff,
	// source detection and charging
	output reg o_source_detect_start_ff,
	output reg [6:0] o_therm_limit_degc_ff,
	output reg o_charge_active_ff,
	output reg o_boost_active_ff,
	output reg [11:0] o_precharge_exit_mv_ff,
	output reg [7:0] o_recharge_offset_mv_ff,
	// control three settings
	output reg o_light_load_pulse_mode_ff,
	output reg [5:0] o_finish_timer_min_ff,
	// temperature zones
	output reg o_hot_zone_suspend_ff,
	output reg o_hot_zone_charge_regulation_voltage_keep_ff,
	output reg [13:0] o_hot_zone_charge_regulation_voltage_mv_ff,
	output reg [6:0] o_hot_zone_current_pct_ff,
	output reg o_cold_zone_suspend_ff,
	output reg [6:0] o_cold_zone_current_pct_ff
);

	// ------------------------------------------------------------------
	// decode functions
	// ------------------------------------------------------------------
	function [6:0] therm_degc;
		input [1:0] code;
		begin
			case (code)
				2'b00: therm_degc = 7'd60;
				2'b01: therm_degc = 7'd80;
				2'b10: therm_degc = 7'd100;
				default: therm_degc = 7'd120;
			endcase
		end
	endfunction

	function [11:0] precharge_mv;
		input sel;
		begin
			precharge_mv = sel ? 12'd3000 : 12'd2800;
		end
	endfunction

	// 50 mV base so the reset code 01 lands on the 100 mV default
	function [7:0] recharge_mv;
		input [1:0] code;
		begin
			recharge_mv = 8'd50 + (code[1] ? 8'd100 : 8'd0) + (code[0] ? 8'd50 : 8'd0);
		end
	endfunction

	function [5:0] finish_min;
		input [1:0] code;
		begin
			case (code)
				2'b01: finish_min = 6'd15;
				2'b10: finish_min = 6'd30;
				2'b11: finish_min = 6'd45;
				default: finish_min = 6'd0;
			endcase
		end
	endfunction

	function [13:0] hot_charge_regulation_voltage_mv;
		input [1:0] code;
		begin
			hot_charge_regulation_voltage_mv = (code == 2'b10) ? 14'd8300 : 14'd8000;
		end
	endfunction

	// shared by both zones: 0 suspends, 1..3 pick 20, 40, 100 percent
	function [6:0] zone_pct;
		input [1:0] code;
		begin
			case (code)
				2'b01: zone_pct = 7'd20;
				2'b10: zone_pct = 7'd40;
				2'b11: zone_pct = 7'd100;
				default: zone_pct = 7'd0;
			endcase
		end
	endfunction

	// ------------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------------
	localparam [7:0] L_RST_TWO = `CCR_RST_CONTROL_TWO;
	localparam [7:0] L_RST_THREE = `CCR_RST_CONTROL_THREE;
	localparam [7:0] L_RST_ZONE = `CCR_RST_ZONE_LIMITS;

	reg auto_detect_ff;
	reg [1:0] therm_code_ff;
	reg charge_enable_ff;
	reg precharge_sel_ff;
	reg [1:0] recharge_code_ff;
	reg pulse_off_ff;
	reg [1:0] finish_code_ff;
	reg [1:0] hot_v_code_ff;
	reg hot_i_sel_ff;
	reg [1:0] cold_i_code_ff;

	wire wd_expire;
	wire wr_two;
	wire wr_three;
	wire wr_zone;

	assign wr_two = i_reg_wr && (i_reg_addr == `CCR_OFS_CONTROL_TWO);
	assign wr_three = i_reg_wr && (i_reg_addr == `CCR_OFS_CONTROL_THREE);
	assign wr_zone = i_reg_wr && (i_reg_addr == `CCR_OFS_ZONE_LIMITS);
	assign o_watchdog_expire = wd_expire;

	// watchdog-resettable fields restored
	// defaults win over a host write landing in the same cycle
	always @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			auto_detect_ff <= L_RST_TWO[`CCR_TWO_AUTO_DET_BIT];
			therm_code_ff <= L_RST_TWO[`CCR_TWO_THERM_HI:`CCR_TWO_THERM_LO];
			charge_enable_ff <= L_RST_TWO[`CCR_TWO_CHG_EN_BIT];
			precharge_sel_ff <= L_RST_TWO[`CCR_TWO_PRECHG_BIT];
		end else if (i_clk_en) begin
			if (i_reg_reset || wd_expire) begin
				auto_detect_ff <= L_RST_TWO[`CCR_TWO_AUTO_DET_BIT];
				therm_code_ff <= L_RST_TWO[`CCR_TWO_THERM_HI:`CCR_TWO_THERM_LO];
				charge_enable_ff <= L_RST_TWO[`CCR_TWO_CHG_EN_BIT];
				precharge_sel_ff <= L_RST_TWO[`CCR_TWO_PRECHG_BIT];
			end else if (wr_two) begin
				auto_detect_ff <= i_reg_wdata[`CCR_TWO_AUTO_DET_BIT];
				therm_code_ff <= i_reg_wdata[`CCR_TWO_THERM_HI:`CCR_TWO_THERM_LO];
				charge_enable_ff <= i_reg_wdata[`CCR_TWO_CHG_EN_BIT];
				precharge_sel_ff <= i_reg_wdata[`CCR_TWO_PRECHG_BIT];
			end
		end
	end

	always @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			recharge_code_ff <= L_RST_TWO[`CCR_TWO_RECHG_HI:`CCR_TWO_RECHG_LO];
			pulse_off_ff <= L_RST_THREE[`CCR_THREE_PULSE_OFF_BIT];
		end else if (i_clk_en) begin
			if (i_reg_reset) begin
				recharge_code_ff <= L_RST_TWO[`CCR_TWO_RECHG_HI:`CCR_TWO_RECHG_LO];
				pulse_off_ff <= L_RST_THREE[`CCR_THREE_PULSE_OFF_BIT];
			end else begin
				if (wr_two) begin
					recharge_code_ff <= i_reg_wdata[`CCR_TWO_RECHG_HI:`CCR_TWO_RECHG_LO];
				end
				if (wr_three) begin
					pulse_off_ff <= i_reg_wdata[`CCR_THREE_PULSE_OFF_BIT];
				end
			end
		end
	end

	// kick sets, then clears itself
	// a fresh kick written while the last one clears is kept
	always @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_watchdog_kick_ff <= L_RST_THREE[`CCR_THREE_KICK_BIT];
			finish_code_ff <= L_RST_THREE[`CCR_THREE_FINISH_HI:`CCR_THREE_FINISH_LO];
		end else if (i_clk_en) begin
			if (i_reg_reset || wd_expire) begin
				o_watchdog_kick_ff <= L_RST_THREE[`CCR_THREE_KICK_BIT];
				finish_code_ff <= L_RST_THREE[`CCR_THREE_FINISH_HI:`CCR_THREE_FINISH_LO];
			end else if (wr_three) begin
				o_watchdog_kick_ff <= i_reg_wdata[`CCR_THREE_KICK_BIT];
				finish_code_ff <= i_reg_wdata[`CCR_THREE_FINISH_HI:`CCR_THREE_FINISH_LO];
			end else begin
				o_watchdog_kick_ff <= 1'b0;
			end
		end
	end

	always @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			hot_v_code_ff <= L_RST_ZONE[`CCR_ZONE_HOT_V_HI:`CCR_ZONE_HOT_V_LO];
			hot_i_sel_ff <= L_RST_ZONE[`CCR_ZONE_HOT_I_BIT];
			cold_i_code_ff <= L_RST_ZONE[`CCR_ZONE_COLD_I_HI:`CCR_ZONE_COLD_I_LO];
		end else if (i_clk_en) begin
			if (i_reg_reset || wd_expire) begin
				hot_v_code_ff <= L_RST_ZONE[`CCR_ZONE_HOT_V_HI:`CCR_ZONE_HOT_V_LO];
				hot_i_sel_ff <= L_RST_ZONE[`CCR_ZONE_HOT_I_BIT];
				cold_i_code_ff <= L_RST_ZONE[`CCR_ZONE_COLD_I_HI:`CCR_ZONE_COLD_I_LO];
			end else if (wr_zone) begin
				hot_v_code_ff <= i_reg_wdata[`CCR_ZONE_HOT_V_HI:`CCR_ZONE_HOT_V_LO];
				hot_i_sel_ff <= i_reg_wdata[`CCR_ZONE_HOT_I_BIT];
				cold_i_code_ff <= i_reg_wdata[`CCR_ZONE_COLD_I_HI:`CCR_ZONE_COLD_I_LO];
			end
		end
	end

	// ------------------------------------------------------------------
	// read path
	// ------------------------------------------------------------------
	reg [7:0] nxt_rdata;

	always @* begin
		nxt_rdata = 8'h00;
		case (i_reg_addr)
			`CCR_OFS_CONTROL_TWO: begin
				nxt_rdata[`CCR_TWO_RSVD_BIT] = 1'b0;
				nxt_rdata[`CCR_TWO_AUTO_DET_BIT] = auto_detect_ff;
				nxt_rdata[`CCR_TWO_THERM_HI:`CCR_TWO_THERM_LO] = therm_code_ff;
				nxt_rdata[`CCR_TWO_CHG_EN_BIT] = charge_enable_ff;
				nxt_rdata[`CCR_TWO_PRECHG_BIT] = precharge_sel_ff;
				nxt_rdata[`CCR_TWO_RECHG_HI:`CCR_TWO_RECHG_LO] = recharge_code_ff;
			end
			`CCR_OFS_CONTROL_THREE: begin
				nxt_rdata = `CCR_THREE_RO_VALUE;
				nxt_rdata[`CCR_THREE_PULSE_OFF_BIT] = pulse_off_ff;
				nxt_rdata[`CCR_THREE_KICK_BIT] = o_watchdog_kick_ff;
				nxt_rdata[`CCR_THREE_FINISH_HI:`CCR_THREE_FINISH_LO] = finish_code_ff;
			end
			`CCR_OFS_ZONE_LIMITS: begin
				nxt_rdata[`CCR_ZONE_HOT_V_HI:`CCR_ZONE_HOT_V_LO] = hot_v_code_ff;
				nxt_rdata[`CCR_ZONE_HOT_I_BIT] = hot_i_sel_ff;
				nxt_rdata[`CCR_ZONE_COLD_I_HI:`CCR_ZONE_COLD_I_LO] = cold_i_code_ff;
			end
			// unmapped offsets read zero
			default: nxt_rdata = 8'h00;
		endcase
	end

	// read data holds until the next read strobe
	always @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_reg_rdata_ff <= 8'h00;
		end else if (i_clk_en && i_reg_rd) begin
			o_reg_rdata_ff <= nxt_rdata;
		end
	end

	// ------------------------------------------------------------------
	// watchdog
	// ------------------------------------------------------------------
	// restart on kick
	ccr_watchdog_timer #(
		.P_BASE_CYCLES(P_WD_BASE_CYCLES)
	) u_watchdog (
		.i_clk_sys(i_clk_sys),
		.i_rst_b(i_rst_b),
		.i_clk_en(i_clk_en),
		.i_period_sel(i_watchdog_period_sel),
		.i_kick(o_watchdog_kick_ff),
		.o_expire_ff(wd_expire)
	);

	// ------------------------------------------------------------------
	// input power plug-in detection
	// ------------------------------------------------------------------
	reg [2:0] pwr_sync_ff;
	reg pwr_level_ff;

	// a change counts only once stages two and three agree
	always @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pwr_sync_ff <= 3'b000;
			pwr_level_ff <= 1'b0;
			o_source_detect_start_ff <= 1'b0;
		end else if (i_clk_en) begin
			pwr_sync_ff <= {pwr_sync_ff[1:0], i_input_bus_power};
			if (pwr_sync_ff[1] == pwr_sync_ff[2]) begin
				pwr_level_ff <= pwr_sync_ff[2];
			end
			o_source_detect_start_ff <= auto_detect_ff && !pwr_level_ff &&
				(pwr_sync_ff[1] == pwr_sync_ff[2]) && pwr_sync_ff[2];
		end
	end

	// ------------------------------------------------------------------
	// decoded settings
	// ------------------------------------------------------------------
	// one cycle behind the register bits, so each reset value is the
	// decode of the matching register default
	always @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_therm_limit_degc_ff <= therm_degc(L_RST_TWO[`CCR_TWO_THERM_HI:`CCR_TWO_THERM_LO]);
			o_charge_active_ff <= L_RST_TWO[`CCR_TWO_CHG_EN_BIT];
			o_boost_active_ff <= 1'b0;
			o_precharge_exit_mv_ff <= precharge_mv(L_RST_TWO[`CCR_TWO_PRECHG_BIT]);
			o_recharge_offset_mv_ff <= recharge_mv(L_RST_TWO[`CCR_TWO_RECHG_HI:`CCR_TWO_RECHG_LO]);
			o_light_load_pulse_mode_ff <= ~L_RST_THREE[`CCR_THREE_PULSE_OFF_BIT];
			o_finish_timer_min_ff <= 6'd0;
			o_hot_zone_suspend_ff <= 1'b0;
			o_hot_zone_charge_regulation_voltage_keep_ff <= 1'b0;
			o_hot_zone_charge_regulation_voltage_mv_ff <= 14'd8000;
			o_hot_zone_current_pct_ff <= 7'd100;
			o_cold_zone_suspend_ff <= 1'b0;
			o_cold_zone_current_pct_ff <= 7'd20;
		end else if (i_clk_en) begin
			o_therm_limit_degc_ff <= therm_degc(therm_code_ff);
			o_charge_active_ff <= charge_enable_ff;
			o_boost_active_ff <= i_reverse_boost_enable && !charge_enable_ff;
			o_precharge_exit_mv_ff <= precharge_mv(precharge_sel_ff);
			o_recharge_offset_mv_ff <= recharge_mv(recharge_code_ff);
			o_light_load_pulse_mode_ff <= !pulse_off_ff;
			o_finish_timer_min_ff <= finish_min(finish_code_ff);
			o_hot_zone_suspend_ff <= (hot_v_code_ff == 2'b00);
			o_hot_zone_charge_regulation_voltage_keep_ff <= (hot_v_code_ff == 2'b11);
			o_hot_zone_charge_regulation_voltage_mv_ff <= hot_charge_regulation_voltage_mv(hot_v_code_ff);
			o_hot_zone_current_pct_ff <= zone_pct({1'b1, hot_i_sel_ff});
			o_cold_zone_suspend_ff <= (cold_i_code_ff == 2'b00);
			o_cold_zone_current_pct_ff <= zone_pct(cold_i_code_ff);
		end
	end

endmodule // ccr_control_regs

`default_nettype wire

/* tb/ccr_regs_monitor.sv */
/* assertion checker for the charger control register block
   assumes it is bound to ccr_control_regs, one clock domain */
`timescale 1ns/100ps
`default_nettype none
module ccr_regs_monitor #(
	parameter [31:0] P_WD_BASE_CYCLES = 32'h0000_0010
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_clk_en,
	// register port
	input wire logic i_reg_reset,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [7:0] o_reg_rdata_ff,
	// status and decoded settings
	input wire logic o_watchdog_expire,
	input wire logic o_watchdog_kick_ff,
	input wire logic o_source_detect_start_ff,
	input wire logic [6:0] o_therm_limit_degc_ff,
	input wire logic o_charge_active_ff,
	input wire logic o_boost_active_ff,
	input wire logic [7:0] o_recharge_offset_mv_ff,
	input wire logic o_light_load_pulse_mode_ff
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_b);
	wire logic rd_en = i_reg_rd && i_clk_en;
	wire logic kick_wr = i_reg_wr && i_reg_addr == 8'h07 && i_reg_wdata[6];
	a_kick_set: assert property (
		kick_wr && i_clk_en && !i_reg_reset && !o_watchdog_expire |=> o_watchdog_kick_ff
	) else $error("kick bit not set by host write");
	a_kick_clear: assert property (
		o_watchdog_kick_ff && i_clk_en && !kick_wr |=> !o_watchdog_kick_ff
	) else $error("kick bit did not clear itself");
	a_two_bit7: assert property (
		rd_en && i_reg_addr == 8'h06 |=> !o_reg_rdata_ff[7]
	) else $error("control two bit 7 read as one");
	a_three_low: assert property (
		rd_en && i_reg_addr == 8'h07 |=> o_reg_rdata_ff[3:0] == 4'h2
	) else $error("control three low nibble wrong");
	a_zone_high: assert property (
		rd_en && i_reg_addr == 8'h08 |=> o_reg_rdata_ff[7:5] == 3'h0
	) else $error("zone limits high bits not zero");
	a_boost_excl: assert property (
		o_charge_active_ff |-> !o_boost_active_ff
	) else $error("boost allowed while charging");
	a_detect_once: assert property (
		o_source_detect_start_ff && i_clk_en |=> !o_source_detect_start_ff
	) else $error("detection start longer than one cycle");
	a_reset_dflt: assert property (
		i_reg_reset && i_clk_en ##1 i_clk_en |=> o_therm_limit_degc_ff == 7'h78
			&& o_recharge_offset_mv_ff == 8'h64 && o_light_load_pulse_mode_ff
	) else $error("settings not at defaults after register reset");
	// write-free window so a late host write cannot mask the restore
	a_wd_restore: assert property (
		o_watchdog_expire && i_clk_en && !i_reg_wr && !i_reg_reset ##1 i_clk_en && !i_reg_wr
			|=> o_therm_limit_degc_ff == 7'h78 && o_charge_active_ff
	) else $error("expiry did not restore settings");
	a_wd_keeps: assert property (
		o_watchdog_expire && i_clk_en && !i_reg_wr && !i_reg_reset ##1 i_clk_en && !i_reg_wr
			|=> $stable(o_recharge_offset_mv_ff) && $stable(o_light_load_pulse_mode_ff)
	) else $error("expiry changed a kept field");
endmodule // ccr_regs_monitor
bind ccr_control_regs ccr_regs_monitor #(.P_WD_BASE_CYCLES(P_WD_BASE_CYCLES)) ccr_regs_monitor_inst (
	.i_clk_sys, .i_rst_b, .i_clk_en, .i_reg_reset, .i_reg_wr, .i_reg_rd, .i_reg_addr,
	.i_reg_wdata, .o_reg_rdata_ff, .o_watchdog_expire, .o_watchdog_kick_ff,
	.o_source_detect_start_ff, .o_therm_limit_degc_ff, .o_charge_active_ff,
	.o_boost_active_ff, .o_recharge_offset_mv_ff, .o_light_load_pulse_mode_ff
);
`default_nettype wire

/* tb/ccr_host_model.sv */
/* host side of the register access port, standing for the serial slave
   assumes callers enter its tasks just after a rising clock edge */
`timescale 1ns/100ps
`default_nettype none
module ccr_host_model (
	// clock
	input wire logic i_clk_sys,
	// register access port
	output logic o_reg_wr,
	output logic o_reg_rd,
	output logic [7:0] o_reg_addr,
	output logic [7:0] o_reg_wdata
);
	initial begin
		o_reg_wr = 1'b0;
		o_reg_rd = 1'b0;
		o_reg_addr = 8'h00;
		o_reg_wdata = 8'h00;
	end
	// idle lines toggle so a stale value never passes for a request
	task automatic cyc(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d);
		o_reg_wr = wr;
		o_reg_rd = rd;
		o_reg_addr = (wr || rd) ? a : ~o_reg_addr;
		o_reg_wdata = wr ? d : ~o_reg_wdata;
		@(posedge i_clk_sys);
		#1;
	endtask
	task automatic kick();
		cyc(1'b1, 1'b0, 8'h07, 8'h40);
	endtask
endmodule // ccr_host_model
`default_nettype wire

/* tb/tb_ccr_control_regs.sv */
/* self-checking bench for the charger control registers
   assumes the host model is the only driver of the register port */
`timescale 1ns/100ps
`default_nettype none
module tb_ccr_control_regs;
	// short watchdog base so the three periods fit a brief run
	localparam logic [31:0] WD = 32'h0000_0010;
	logic i_clk_sys, i_rst_b, i_clk_en, i_reg_reset, i_reg_wr, i_reg_rd;
	logic i_input_bus_power, i_reverse_boost_enable, o_watchdog_expire, o_watchdog_kick_ff;
	logic o_source_detect_start_ff, o_charge_active_ff, o_boost_active_ff;
	logic o_light_load_pulse_mode_ff, o_hot_zone_suspend_ff, o_hot_zone_charge_regulation_voltage_keep_ff;
	logic o_cold_zone_suspend_ff;
	logic [1:0] i_watchdog_period_sel;
	logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata_ff, o_recharge_offset_mv_ff;
	logic [6:0] o_therm_limit_degc_ff, o_hot_zone_current_pct_ff, o_cold_zone_current_pct_ff;
	logic [11:0] o_precharge_exit_mv_ff;
	logic [5:0] o_finish_timer_min_ff;
	logic [13:0] o_hot_zone_charge_regulation_voltage_mv_ff;
	logic [7:0] exp_q[$];
	logic rd_d = 1'b0;
	int mismatches = 0;
	int checks_done = 0;
	ccr_host_model ccr_host_model_inst (
		.i_clk_sys, .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd), .o_reg_addr(i_reg_addr),
		.o_reg_wdata(i_reg_wdata)
	);
	ccr_control_regs #(.P_WD_BASE_CYCLES(WD)) ccr_control_regs_inst (
		.i_clk_sys, .i_rst_b, .i_clk_en, .i_reg_reset, .i_reg_wr, .i_reg_rd, .i_reg_addr,
		.i_reg_wdata, .o_reg_rdata_ff, .i_input_bus_power, .i_reverse_boost_enable,
		.i_watchdog_period_sel, .o_watchdog_expire, .o_watchdog_kick_ff,
		.o_source_detect_start_ff, .o_therm_limit_degc_ff, .o_charge_active_ff,
		.o_boost_active_ff, .o_precharge_exit_mv_ff, .o_recharge_offset_mv_ff,
		.o_light_load_pulse_mode_ff, .o_finish_timer_min_ff, .o_hot_zone_suspend_ff,
		.o_hot_zone_charge_regulation_voltage_keep_ff, .o_hot_zone_charge_regulation_voltage_mv_ff, .o_hot_zone_current_pct_ff,
		.o_cold_zone_suspend_ff, .o_cold_zone_current_pct_ff
	);
	initial begin
		i_clk_sys = 1'b0;
		forever #25 i_clk_sys = ~i_clk_sys;
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t value %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		ccr_host_model_inst.cyc(1'b1, 1'b0, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		ccr_host_model_inst.cyc(1'b0, 1'b1, a, 8'h00);
	endtask
	task automatic nop();
		ccr_host_model_inst.cyc(1'b0, 1'b0, 8'h00, 8'h00);
	endtask
	task automatic dec(input logic [7:0] r6, input logic [7:0] r7, input logic [7:0] r8);
		logic [6:0] cold;
		cold = r8[1] ? (r8[0] ? 7'h64 : 7'h28) : (r8[0] ? 7'h14 : 7'h00);
		chk(o_therm_limit_degc_ff, 7'h3c + 7'h14 * r6[5:4]);
		chk({o_charge_active_ff, o_boost_active_ff}, {r6[3], i_reverse_boost_enable & !r6[3]});
		chk(o_precharge_exit_mv_ff, r6[2] ? 12'hbb8 : 12'haf0);
		chk(o_recharge_offset_mv_ff, 8'h32 + 8'h64 * r6[1] + 8'h32 * r6[0]);
		chk(o_light_load_pulse_mode_ff, !r7[7]);
		chk(o_finish_timer_min_ff, 6'h0f * r7[5:4]);
		chk({o_hot_zone_suspend_ff, o_hot_zone_charge_regulation_voltage_keep_ff}, {r8[4:3] == 2'h0, r8[4:3] == 2'h3});
		chk(o_hot_zone_charge_regulation_voltage_mv_ff, (r8[4:3] == 2'h2) ? 14'h206c : 14'h1f40);
		chk(o_hot_zone_current_pct_ff, r8[2] ? 7'h64 : 7'h28);
		chk({o_cold_zone_suspend_ff, o_cold_zone_current_pct_ff}, {r8[1:0] == 2'h0, cold});
	endtask
	always @(posedge i_clk_sys) begin
		rd_d <= i_reg_rd && i_clk_en;
	end
	// read data has settled by the falling edge after the taking edge
	always @(negedge i_clk_sys) begin
		if (rd_d && exp_q.size() > 0) begin
			chk(o_reg_rdata_ff, exp_q.pop_front());
		end
	end
	initial begin
		logic [7:0] d, e6, e7, e8;
		int n, e;
		i_rst_b = 1'b0;
		i_clk_en = 1'b1;
		i_reg_reset = 1'b0;
		i_input_bus_power = 1'b0;
		i_reverse_boost_enable = 1'b0;
		i_watchdog_period_sel = 2'h0;
		d = 8'($urandom(32'h5ad8_873d));
		repeat (8) @(posedge i_clk_sys);
		#1;
		i_rst_b = 1'b1;
		rd(8'h06, 8'h7d);
		rd(8'h07, 8'h02);
		rd(8'h08, 8'h0d);
		nop();
		dec(8'h7d, 8'h02, 8'h0d);
		for (int i = 0; i < 4; i++) begin
			d = 8'($urandom);
			// walk every boost and charge pairing and both single-bit settings
			i_reverse_boost_enable = i[1];
			e6 = {d[7:6], i[1:0], i[0], ~i[1], i[1:0]};
			e7 = {d[7], 1'b0, i[1:0], d[3:0]};
			e8 = {d[7:5], i[1:0], i[0], i[1:0]};
			wr(8'h06, e6);
			wr(8'h07, e7);
			wr(8'h08, e8);
			rd(8'h06, {1'b0, e6[6:0]});
			rd(8'h07, {e7[7:4], 4'h2});
			rd(8'h08, {3'h0, e8[4:0]});
			nop();
			dec(e6, e7, e8);
		end
		wr(8'h09, 8'hff);
		rd(8'h09, 8'h00);
		ccr_host_model_inst.kick();
		chk(o_watchdog_kick_ff, 1'b1);
		rd(8'h07, 8'h42);
		chk(o_watchdog_kick_ff, 1'b0);
		rd(8'h07, 8'h02);
		wr(8'h06, 8'h00);
		wr(8'h07, 8'hb0);
		wr(8'h08, 8'h00);
		for (int s = 1; s < 4; s++) begin
			i_watchdog_period_sel = s[1:0];
			e = int'(WD) << (s - 1);
			n = 0;
			while (o_watchdog_expire !== 1'b1 && n < 300) begin
				nop();
				n++;
			end
			if (n == 300) begin
				mismatches++;
				results();
			end
			chk(n >= e - 2 && n <= e + 2, 1'b1);
			i_watchdog_period_sel = 2'h0;
			nop();
		end
		rd(8'h06, 8'h7c);
		rd(8'h07, 8'h82);
		rd(8'h08, 8'h0d);
		nop();
		dec(8'h7c, 8'h82, 8'h0d);
		i_watchdog_period_sel = 2'h1;
		n = 0;
		repeat (6) begin
			ccr_host_model_inst.kick();
			repeat (8) begin
				nop();
				n += (o_watchdog_expire !== 1'b0);
			end
		end
		i_watchdog_period_sel = 2'h0;
		repeat (64) begin
			nop();
			n += (o_watchdog_expire !== 1'b0);
		end
		chk(n, 0);
		wr(8'h06, 8'h03);
		wr(8'h07, 8'hb0);
		i_reg_reset = 1'b1;
		wr(8'h08, 8'h1f);
		i_reg_reset = 1'b0;
		rd(8'h06, 8'h7d);
		rd(8'h07, 8'h02);
		rd(8'h08, 8'h0d);
		nop();
		dec(8'h7d, 8'h02, 8'h0d);
		// clock enable low freezes state, so this write must not land
		i_clk_en = 1'b0;
		wr(8'h06, 8'h00);
		i_clk_en = 1'b1;
		rd(8'h06, 8'h7d);
		nop();
		n = 0;
		for (int p = 0; p < 3; p++) begin
			if (p == 2) begin
				wr(8'h06, 8'h3d);
			end
			i_input_bus_power = (p != 1);
			repeat (10) begin
				nop();
				n += (o_source_detect_start_ff !== 1'b0);
			end
		end
		chk(n, 1);
		results();
	end
endmodule // tb_ccr_control_regs
`default_nettype wire
